// >>> src/config_field_access_straps.sv
// config field bank with strap capture and logic-chain test output
// assumes: straps and test pins are asynchronous, access port is on mclk
//
// Behaviour
// [R01] a read returns the selected field's current value
// [R02] writable bits store whatever software writes
// [R03] set bits go to one on a written one, zero has no effect
// [R04] clear bits go to zero on a written one, zero has no effect
// [R05] update bits follow hardware events regardless of software writes
// [R06] card-form strap picks one of two header layouts, high means bus
// [R07] card-form strap picks output buffer mode, low means card slot
// [R08] aux flag high means auxiliary power and enables deep power-off support
// [R09] in test mode the chain result drives the test pin, else idle
// [R10] power management field shows the aux flag state
`timescale 1ns/100ps
`default_nettype none
module config_field_access_straps #(
	parameter int CHAIN_W = cfg_access_pkg::CHAIN_W
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// field access port
	input  wire logic               acc_wr,
	input  wire logic               acc_rd,
	input  wire logic [1:0]         acc_sel,
	input  wire logic [15:0]        acc_wdata,
	output var  logic [15:0]        acc_rdata,
	output var  logic               acc_rvalid,
	// hardware events
	input  wire logic [15:0]        hw_status_set,
	input  wire logic               hw_pm_event,
	// straps and test pins
	input  wire logic               card_form_select_n,
	input  wire logic               aux_power_present,
	input  wire logic               chain_test_mode,
	input  wire logic [CHAIN_W-1:0] chain_in,
	// derived configuration
	output var  logic               header_layout,
	output var  logic               buffer_mode,
	output var  logic               d3cold_ok,
	output var  logic [1:0]         power_state,
	output var  logic               logic_chain_test_out
);
	// ==================================================
	// pin synchronisers
	logic               card_s1, card_s2;
	logic               aux_s1, aux_s2;
	logic               tm_s1, tm_s2;
	logic [CHAIN_W-1:0] ch_s1, ch_s2;

	always_ff @(posedge mclk) begin
		card_s1 <= card_form_select_n;
		card_s2 <= card_s1;
		aux_s1  <= aux_power_present;
		aux_s2  <= aux_s1;
		tm_s1   <= chain_test_mode;
		tm_s2   <= tm_s1;
		ch_s1   <= chain_in;
		ch_s2   <= ch_s1;
	end

	// ==================================================
	// strap capture, once after reset release
	logic strap_taken;

	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_taken   <= 1'b0;
			header_layout <= cfg_access_pkg::LAYOUT_BUS;
			buffer_mode   <= cfg_access_pkg::BUF_BUS;
		end else if (!strap_taken) begin
			strap_taken   <= 1'b1;
			// layout and buffers never change mid-run
			header_layout <= card_s2 ? cfg_access_pkg::LAYOUT_BUS
			                         : cfg_access_pkg::LAYOUT_CARD; // [R06]
			buffer_mode   <= card_s2 ? cfg_access_pkg::BUF_BUS
			                         : cfg_access_pkg::BUF_CARD; // [R07]
		end
	end

	// ==================================================
	// aux power tracking, live
	always_ff @(posedge mclk) begin
		if (rst) begin
			d3cold_ok <= 1'b0;
		end else begin
			d3cold_ok <= aux_s2; // [R08]
		end
	end

	// ==================================================
	// field bank
	logic [15:0] ctrl_q, stat_q, enab_q, pm_q;
	logic [15:0] pm_set;

	assign pm_set = {hw_pm_event & d3cold_ok | hw_pm_event, 15'h0000};

	field_cell #(
		.W     (cfg_access_pkg::FIELD_W),
		.WMASK (cfg_access_pkg::CTRL_WMASK),
		.SMASK (cfg_access_pkg::NO_MASK),
		.CMASK (cfg_access_pkg::NO_MASK),
		.UMASK (cfg_access_pkg::NO_MASK),
		.RVAL  (cfg_access_pkg::FIELD_RESET)
	) u_ctrl (
		.mclk   (mclk),
		.rst    (rst),
		.wr     (acc_wr && acc_sel == cfg_access_pkg::FLD_CTRL),
		.wdata  (acc_wdata),
		.hw_set (16'h0000),
		.value  (ctrl_q)
	);

	field_cell #(
		.W     (cfg_access_pkg::FIELD_W),
		.WMASK (cfg_access_pkg::NO_MASK),
		.SMASK (cfg_access_pkg::NO_MASK),
		.CMASK (cfg_access_pkg::STAT_CMASK),
		.UMASK (cfg_access_pkg::STAT_UMASK),
		.RVAL  (cfg_access_pkg::FIELD_RESET)
	) u_stat (
		.mclk   (mclk),
		.rst    (rst),
		.wr     (acc_wr && acc_sel == cfg_access_pkg::FLD_STATUS),
		.wdata  (acc_wdata),
		.hw_set (hw_status_set),
		.value  (stat_q)
	);

	field_cell #(
		.W     (cfg_access_pkg::FIELD_W),
		.WMASK (cfg_access_pkg::NO_MASK),
		.SMASK (cfg_access_pkg::ENAB_SMASK),
		.CMASK (cfg_access_pkg::NO_MASK),
		.UMASK (cfg_access_pkg::NO_MASK),
		.RVAL  (cfg_access_pkg::FIELD_RESET)
	) u_enab (
		.mclk   (mclk),
		.rst    (rst),
		.wr     (acc_wr && acc_sel == cfg_access_pkg::FLD_ENABLE),
		.wdata  (acc_wdata),
		.hw_set (16'h0000),
		.value  (enab_q)
	);

	field_cell #(
		.W     (cfg_access_pkg::FIELD_W),
		.WMASK (cfg_access_pkg::PM_WMASK),
		.SMASK (cfg_access_pkg::NO_MASK),
		.CMASK (cfg_access_pkg::PM_CMASK),
		.UMASK (cfg_access_pkg::PM_UMASK),
		.RVAL  (cfg_access_pkg::FIELD_RESET)
	) u_pm (
		.mclk   (mclk),
		.rst    (rst),
		.wr     (acc_wr && acc_sel == cfg_access_pkg::FLD_PMCSR),
		.wdata  (acc_wdata),
		.hw_set (pm_set),
		.value  (pm_q)
	);

	// ==================================================
	// power state output
	always_ff @(posedge mclk) begin
		if (rst) begin
			power_state <= 2'h0;
		end else begin
			power_state <= pm_q[cfg_access_pkg::PM_STATE_LSB +: 2];
		end
	end

	// ==================================================
	// read path, answer one cycle after the strobe
	logic [15:0] pm_view;

	always_comb begin
		pm_view = pm_q;
		pm_view[cfg_access_pkg::PM_AUX_BIT] = d3cold_ok; // [R10]
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_rdata  <= 16'h0000;
			acc_rvalid <= 1'b0;
		end else begin
			acc_rvalid <= acc_rd;
			if (acc_rd) begin
				case (acc_sel)
					cfg_access_pkg::FLD_CTRL:   acc_rdata <= ctrl_q; // [R01]
					cfg_access_pkg::FLD_STATUS: acc_rdata <= stat_q; // [R01]
					cfg_access_pkg::FLD_ENABLE: acc_rdata <= enab_q; // [R01]
					cfg_access_pkg::FLD_PMCSR:  acc_rdata <= pm_view; // [R01]
					default:                    acc_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ==================================================
	// logic-chain test: each stage nands the previous result
	logic [CHAIN_W:0] chain;

	assign chain[0] = 1'b1;
	genvar k;
	generate
		for (k = 0; k < CHAIN_W; k++) begin : g_chain
			assign chain[k+1] = ~(chain[k] & ch_s2[k]);
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			logic_chain_test_out <= 1'b0;
		end else begin
			// pin idles low outside test mode
			logic_chain_test_out <= tm_s2 ? chain[CHAIN_W] : 1'b0; // [R09]
		end
	end

	// ==================================================
	// checks
	sequence s_ctrl_wr;
		acc_wr && acc_sel == cfg_access_pkg::FLD_CTRL;
	endsequence

	sequence s_rd_ctrl;
		acc_rd && acc_sel == cfg_access_pkg::FLD_CTRL && !acc_wr;
	endsequence

	sequence s_strap_capture;
		!strap_taken ##1 strap_taken;
	endsequence

	a_read_ctrl: assert property (@(posedge mclk) disable iff (rst)
		s_rd_ctrl |=> acc_rvalid && acc_rdata == $past(ctrl_q))
		else $error("ctrl read mismatch"); // [R01]
	a_write_store: assert property (@(posedge mclk) disable iff (rst)
		s_ctrl_wr |=> ctrl_q == $past(acc_wdata))
		else $error("ctrl write lost"); // [R02]
	a_set_bits: assert property (@(posedge mclk) disable iff (rst)
		acc_wr && acc_sel == cfg_access_pkg::FLD_ENABLE
		|=> enab_q == ($past(enab_q) | $past(acc_wdata)))
		else $error("set field wrong"); // [R03]
	a_clear_bits: assert property (@(posedge mclk) disable iff (rst)
		acc_wr && acc_sel == cfg_access_pkg::FLD_STATUS && hw_status_set == 0
		|=> stat_q == ($past(stat_q) & ~$past(acc_wdata)))
		else $error("clear field wrong"); // [R04]
	a_update_wins: assert property (@(posedge mclk) disable iff (rst)
		hw_status_set != 0 |=> (stat_q & $past(hw_status_set))
		== $past(hw_status_set))
		else $error("hardware update lost"); // [R05]
	a_layout_strap: assert property (@(posedge mclk) disable iff (rst)
		s_strap_capture |-> header_layout == !$past(card_s2, 1))
		else $error("layout strap wrong"); // [R06]
	a_buffer_mode: assert property (@(posedge mclk) disable iff (rst)
		s_strap_capture |-> buffer_mode == !$past(card_s2, 1))
		else $error("buffer mode wrong"); // [R07]
	a_aux_track: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> d3cold_ok == $past(aux_s2))
		else $error("aux flag not tracked"); // [R08]
	a_chain_idle: assert property (@(posedge mclk) disable iff (rst)
		!tm_s2 |=> !logic_chain_test_out)
		else $error("test pin active in normal mode"); // [R09]
	a_pm_aux: assert property (@(posedge mclk) disable iff (rst)
		acc_rd && acc_sel == cfg_access_pkg::FLD_PMCSR
		|=> acc_rdata[cfg_access_pkg::PM_AUX_BIT] == $past(d3cold_ok))
		else $error("pm field ignores aux"); // [R10]
endmodule : config_field_access_straps
`default_nettype wire

// >>> src/cfg_access_pkg.sv
// package: field indices, access masks, reset values and strap codes
// assumes: used by the strap/config top module, which passes these masks to the field cell
package cfg_access_pkg;
	// ==================================================
	// field selection
	localparam int          FIELD_W      = 16;
	localparam logic [1:0]  FLD_CTRL     = 2'h0;
	localparam logic [1:0]  FLD_STATUS   = 2'h1;
	localparam logic [1:0]  FLD_ENABLE   = 2'h2;
	localparam logic [1:0]  FLD_PMCSR    = 2'h3;
	// ==================================================
	// per-field access masks (write, set, clear, update)
	localparam logic [15:0] CTRL_WMASK   = 16'hffff;
	localparam logic [15:0] STAT_CMASK   = 16'hffff;
	localparam logic [15:0] STAT_UMASK   = 16'hffff;
	localparam logic [15:0] ENAB_SMASK   = 16'hffff;
	localparam logic [15:0] PM_WMASK     = 16'h0103;
	localparam logic [15:0] PM_CMASK     = 16'h8000;
	localparam logic [15:0] PM_UMASK     = 16'h8000;
	localparam logic [15:0] NO_MASK      = 16'h0000;
	localparam logic [15:0] FIELD_RESET  = 16'h0000;
	// ==================================================
	// power management field layout
	localparam int          PM_STATE_LSB = 0;
	localparam int          PM_AUX_BIT   = 3;
	localparam int          PM_EVT_BIT   = 15;
	localparam logic [1:0]  PM_D3        = 2'h3;
	// ==================================================
	// strap meanings
	localparam logic        LAYOUT_BUS   = 1'h0;
	localparam logic        LAYOUT_CARD  = 1'h1;
	localparam logic        BUF_BUS      = 1'h0;
	localparam logic        BUF_CARD     = 1'h1;
	localparam int          CHAIN_W      = 8;
endpackage : cfg_access_pkg

// >>> src/field_cell.sv
// one software-visible field with per-bit access behaviour
// assumes: a single write strobe and hardware set pulses on the same clock
`timescale 1ns/100ps
`default_nettype none
module field_cell #(
	parameter int          W     = 16,
	parameter logic [15:0] WMASK = 16'h0000,
	parameter logic [15:0] SMASK = 16'h0000,
	parameter logic [15:0] CMASK = 16'h0000,
	parameter logic [15:0] UMASK = 16'h0000,
	parameter logic [15:0] RVAL  = 16'h0000
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// software write
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	// hardware update
	input  wire logic [W-1:0] hw_set,
	// current value
	output var  logic [W-1:0] value
);
	// ==================================================
	// per-bit behaviour
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (rst) begin
					value[i] <= RVAL[i];
				// hardware set wins over a same-cycle clear
				end else if (hw_set[i] && UMASK[i]) begin
					value[i] <= 1'b1; // [R05]
				end else if (wr) begin
					if (WMASK[i]) begin
						value[i] <= wdata[i]; // [R02]
					end else if (SMASK[i] && wdata[i]) begin
						value[i] <= 1'b1; // [R03]
					end else if (CMASK[i] && wdata[i]) begin
						value[i] <= 1'b0; // [R04]
					end
				end
			end
		end
	endgenerate
endmodule : field_cell
`default_nettype wire

// >>> sim/cfg_host_model.sv
// host-side model: issues field writes and reads on the access port
// assumes: one clock, requests launched at the falling edge of mclk
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
	// clock
	input  wire logic        mclk,
	// access port
	output var  logic        acc_wr,
	output var  logic        acc_rd,
	output var  logic [1:0]  acc_sel,
	output var  logic [15:0] acc_wdata,
	input  wire logic [15:0] acc_rdata,
	input  wire logic        acc_rvalid
);
	initial begin
		acc_wr = 1'h0;
		acc_rd = 1'h0;
		acc_sel = 2'h0;
		acc_wdata = 16'h0000;
	end
	// ==================================================
	// bus cycles
	task automatic write(input logic [1:0] s, input logic [15:0] d);
		@(negedge mclk);
		acc_wr = 1'h1;
		acc_sel = s;
		acc_wdata = d;
		@(negedge mclk);
		acc_wr = 1'h0;
		// released data must not keep looking valid
		acc_wdata = ~d;
	endtask : write
	task automatic read(input logic [1:0] s, output logic [15:0] d);
		d = 16'hxxxx;
		@(negedge mclk);
		acc_rd = 1'h1;
		acc_sel = s;
		@(negedge mclk);
		acc_rd = 1'h0;
		// answer stands one cycle only, so look at each falling edge
		// bounded wait, a lost answer leaves d unknown
		for (int i = 0; i < 4; i++) begin
			if (acc_rvalid === 1'h1) begin
				d = acc_rdata;
				break;
			end
			@(negedge mclk);
		end
	endtask : read
endmodule : cfg_host_model
`default_nettype wire

// >>> sim/config_field_access_straps_tb.sv
// testbench: field access kinds, straps, aux flag and chain test pin
// assumes: host model drives the access port, bench drives the pins
`timescale 1ns/100ps
`default_nettype none
module config_field_access_straps_tb;
	logic        mclk;
	logic        rst;
	logic        acc_wr;
	logic        acc_rd;
	logic [1:0]  acc_sel;
	logic [15:0] acc_wdata;
	logic [15:0] acc_rdata;
	logic        acc_rvalid;
	logic [15:0] hw_status_set;
	logic        hw_pm_event;
	logic        card_n;
	logic        aux;
	logic        tmode;
	logic [7:0]  chain_in;
	logic        header_layout;
	logic        buffer_mode;
	logic        d3cold_ok;
	logic [1:0]  power_state;
	logic        chain_out;
	int          err_total;
	int          num_checks;
	cfg_host_model cfg_host_model_i (.mclk, .acc_wr, .acc_rd, .acc_sel,
		.acc_wdata, .acc_rdata, .acc_rvalid);
	config_field_access_straps config_field_access_straps_i (.mclk, .rst,
		.acc_wr, .acc_rd, .acc_sel, .acc_wdata, .acc_rdata, .acc_rvalid,
		.hw_status_set, .hw_pm_event, .card_form_select_n(card_n),
		.aux_power_present(aux), .chain_test_mode(tmode), .chain_in,
		.header_layout, .buffer_mode, .d3cold_ok, .power_state,
		.logic_chain_test_out(chain_out));
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	// ==================================================
	// compares and closing
	task automatic check_word(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t word %h expected %h", $time, g, e);
		end
	endtask : check_word
	task automatic check_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t bit %b expected %b", $time, g, e);
		end
	endtask : check_bit
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic rd_chk(input logic [1:0] s, input logic [15:0] e);
		logic [15:0] v;
		cfg_host_model_i.read(s, v);
		check_word(v, e);
	endtask : rd_chk
	// ==================================================
	// scenarios
	task automatic do_reset(input logic strap);
		@(negedge mclk);
		rst = 1'h1;
		card_n = strap;
		repeat (4) @(negedge mclk);
		check_bit(header_layout, cfg_access_pkg::LAYOUT_BUS);
		rst = 1'h0;
		repeat (3) @(negedge mclk);
		check_bit(header_layout, strap ? 1'h0 : 1'h1);
		check_bit(buffer_mode, strap ? 1'h0 : 1'h1);
	endtask : do_reset
	task automatic test_ctrl();
		cfg_host_model_i.write(2'h0, 16'ha5c3);
		rd_chk(2'h0, 16'ha5c3);
		cfg_host_model_i.write(2'h0, 16'h5a3c);
		rd_chk(2'h0, 16'h5a3c);
	endtask : test_ctrl
	task automatic test_status();
		@(negedge mclk);
		hw_status_set = 16'h8001;
		@(negedge mclk);
		hw_status_set = 16'h0000;
		rd_chk(2'h1, 16'h8001);
		cfg_host_model_i.write(2'h1, 16'h0001);
		rd_chk(2'h1, 16'h8000);
		cfg_host_model_i.write(2'h1, 16'h0000);
		rd_chk(2'h1, 16'h8000);
	endtask : test_status
	task automatic test_enable();
		cfg_host_model_i.write(2'h2, 16'h0011);
		rd_chk(2'h2, 16'h0011);
		cfg_host_model_i.write(2'h2, 16'h0100);
		rd_chk(2'h2, 16'h0111);
		cfg_host_model_i.write(2'h2, 16'h0000);
		rd_chk(2'h2, 16'h0111);
	endtask : test_enable
	task automatic test_pm();
		cfg_host_model_i.write(2'h3, 16'hffff);
		rd_chk(2'h3, 16'h010b);
		check_word({14'h0000, power_state}, 16'h0003);
		check_bit(d3cold_ok, 1'h1);
		@(negedge mclk);
		hw_pm_event = 1'h1;
		@(negedge mclk);
		hw_pm_event = 1'h0;
		rd_chk(2'h3, 16'h810b);
		cfg_host_model_i.write(2'h3, 16'h8000);
		rd_chk(2'h3, 16'h0008);
		aux = 1'h0;
		repeat (5) @(negedge mclk);
		rd_chk(2'h3, 16'h0000);
		check_bit(d3cold_ok, 1'h0);
	endtask : test_pm
	task automatic test_chain();
		logic [7:0] pats [3] = '{8'hff, 8'h00, 8'h5a};
		logic       v;
		tmode = 1'h1;
		foreach (pats[p]) begin
			chain_in = pats[p];
			v = 1'h1;
			for (int k = 0; k < 8; k++) v = ~(v & pats[p][k]);
			repeat (5) @(negedge mclk);
			check_bit(chain_out, v);
		end
		tmode = 1'h0;
		repeat (5) @(negedge mclk);
		check_bit(chain_out, 1'h0);
	endtask : test_chain
	// ==================================================
	// main sequence and watchdog
	initial begin
		err_total = 0;
		num_checks = 0;
		rst = 1'h1;
		hw_status_set = 16'h0000;
		hw_pm_event = 1'h0;
		card_n = 1'h1;
		aux = 1'h1;
		tmode = 1'h0;
		chain_in = 8'h00;
		do_reset(1'h1);
		test_ctrl();
		test_status();
		test_enable();
		test_pm();
		test_chain();
		do_reset(1'h0);
		results();
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
endmodule : config_field_access_straps_tb
`default_nettype wire
